// *** uerx_regs.vh ***
// Function
// - Received break is handled as framing error
// - Long break closes frame, stores zero word
// - After break wait for high line
// - Idle flag low from start to last data bit
// - Word transfer sets avail flag, may interrupt
// - Four buffered words, fifth overruns
// - Overrun keeps buffer, overwrites shifter, interrupts
// - Overrun clears on status then data read
// - Avail clears once reads empty the buffer, no status needed
// - Noise flag rises with avail, interrupts via error enable
// - Noise flag clears when its word is read, no status needed
// - Error kinds set sticky flags with interrupt
// - Low stop bit sets framing error flag
// - Parity mismatch per type sets parity flag
// - Interrupt is low pulse, nine sources
// - Own tx enables, shared rx enable
// - Status flags read-only, cleared by actions
// - Address detect gates interrupt on top bit
// - Stopped port clock pauses, keeps registers
// - Pin falling edge wakes stopped port
// - Tx flags clear on status then write
// - Sixteen times oversampling, three sample vote
`ifndef UERX_REGS_VH
`define UERX_REGS_VH

`define UERX_OVS_W      4
`define UERX_DECIDE     4'hA
`define UERX_DEPTH      3'h4
`define UERX_WORD_W     9
`define UERX_ENT_W      12
`define UERX_F_NZ       9
`define UERX_F_FE       10
`define UERX_F_PE       11
`define UERX_PAR_EVEN   2'h0
`define UERX_PAR_ODD    2'h1
`define UERX_PAR_MARK   2'h2
`define UERX_PAR_SPACE  2'h3
`define UERX_STK_NZ     0
`define UERX_STK_FE     1
`define UERX_STK_PE     2
`define UERX_WAKE_HOLD  16

`endif

// *** uerx_vote.v ***
`timescale 1ns/1ps
module uerx_vote (
   input  wire clk,
   input  wire reset,
   input  wire tick,
   input  wire din,
   output wire bit_o,
   output wire noise_o
);

   reg [2:0] smp_r;

   // three most recent 16x samples
   always @(posedge clk) begin
      if (reset) begin
         smp_r <= 3'h7;
      end else if (tick) begin
         smp_r <= {smp_r[1:0], din};
      end
   end

   assign bit_o   = (smp_r[0] & smp_r[1]) | (smp_r[1] & smp_r[2]) |
                    (smp_r[0] & smp_r[2]);
   assign noise_o = ~(&smp_r) & (|smp_r);

endmodule // uerx_vote

// *** uerx_top.v ***
`timescale 1ns/1ps
`include "uerx_regs.vh"
module uerx_top #(
   parameter DIV_W     = 16,
   parameter WAKE_HOLD = `UERX_WAKE_HOLD
) (
   input  wire             CLK_SYS,
   input  wire             RESET,
   input  wire             PORT_CLK_RUN,
   input  wire             RX_PIN,
   input  wire [DIV_W-1:0] BAUD_DIV,
   input  wire             PORT_ENABLE,
   input  wire             RECEIVER_ENABLE,
   input  wire             NINE_BIT_SELECT,
   input  wire             PARITY_ENABLE,
   input  wire [1:0]       PARITY_TYPE,
   input  wire             TWO_STOP,
   input  wire [2:0]       RX_TRIG_LEVEL,
   input  wire             RX_IRQ_ENABLE,
   input  wire             TX_EMPTY_IRQ_EN,
   input  wire             TX_IDLE_IRQ_EN,
   input  wire             GLOBAL_ERROR_IRQ_ENABLE,
   input  wire             ADDR_DETECT_ENABLE,
   input  wire             PIN_WAKE_ENABLE,
   input  wire             STATUS_ACCESS,
   input  wire             DATA_READ,
   input  wire             DATA_WRITE,
   input  wire [2:0]       STICKY_CLEAR,
   input  wire             TX_EMPTY_SET,
   input  wire             TX_IDLE_SET,
   output reg  [8:0]       RX_DATA,
   output reg  [2:0]       RX_COUNT,
   output reg              RX_DATA_AVAIL_FLAG,
   output reg              RX_IDLE_FLAG,
   output reg              OVERRUN_FLAG,
   output reg              NOISE_FLAG,
   output reg              FRAME_ERR_FLAG,
   output reg              PARITY_ERR_FLAG,
   output reg              STICKY_NOISE_FLAG,
   output reg              STICKY_FRAME_FLAG,
   output reg              STICKY_PARITY_FLAG,
   output reg              TX_EMPTY_FLAG,
   output reg              TX_IDLE_FLAG,
   output reg              WAKE_EVENT,
   output reg              PORT_IRQ_N
);

   localparam [6:0] S_IDLE  = 7'h01;
   localparam [6:0] S_START = 7'h02;
   localparam [6:0] S_DATA  = 7'h04;
   localparam [6:0] S_PAR   = 7'h08;
   localparam [6:0] S_STOP  = 7'h10;
   localparam [6:0] S_STOP2 = 7'h20;
   localparam [6:0] S_BRK   = 7'h40;

   // expected parity for the selected type
   function par_exp;
      input [1:0] ptype;
      input [8:0] word;
      begin
         case (ptype)
            `UERX_PAR_EVEN: par_exp = ^word;
            `UERX_PAR_ODD:  par_exp = ~(^word);
            `UERX_PAR_MARK: par_exp = 1'b1;
            default:        par_exp = 1'b0;
         endcase
      end
   endfunction

   reg                   rx_m_r;
   reg                   rx_s_r;
   reg                   rx_d_r;
   reg [DIV_W-1:0]       div_r;
   reg [`UERX_OVS_W-1:0] ovs_r;
   reg [3:0]             bit_r;
   reg [6:0]             st_r;
   reg [8:0]             sh_r;
   reg                   nz_r;
   reg                   pe_r;
   reg [`UERX_ENT_W-1:0] mem [0:3];
   reg [1:0]             wr_ptr_r;
   reg [1:0]             rd_ptr_r;
   reg                   stat_seen_r;
   reg                   wake_pend_r;
   reg [7:0]             hold_r;
   reg                   hold_act_r;
   reg                   wake_irq_r;

   wire       run;
   wire       tick;
   wire       vbit;
   wire       vnoise;
   wire       dec;
   wire       rx_on;
   wire       fin;
   wire       fin_fe;
   wire       fin_nz;
   wire       fin_pe;
   wire       msb;
   wire       pop;
   wire       push;
   wire       ovr;
   wire [2:0] cnt_after;
   wire       seq_rd;
   wire       seq_wr;
   wire       e_rx;
   wire       e_adr;
   wire       e_ovr;
   wire       e_err;
   wire       e_tx;
   wire       any_evt;
   wire [3:0] last_bit;

   // a stopped port clock freezes the receive state; the pin crossing and wake detect keep running
   assign run   = PORT_CLK_RUN;
   assign tick  = run & (div_r == BAUD_DIV);
   assign dec   = tick & (ovs_r == `UERX_DECIDE);
   assign rx_on = PORT_ENABLE & RECEIVER_ENABLE & ~hold_act_r;
   assign last_bit = NINE_BIT_SELECT ? 4'h8 : 4'h7;

   // pin crossing; the second stage feeds logic, the third only the wake edge detect
   always @(posedge CLK_SYS) begin
      if (RESET) begin
         rx_m_r <= 1'b1;
         rx_s_r <= 1'b1;
         rx_d_r <= 1'b1;
      end else begin
         rx_m_r <= RX_PIN;
         rx_s_r <= rx_m_r;
         rx_d_r <= rx_s_r;
      end
   end

   always @(posedge CLK_SYS) begin
      if (RESET) begin
         div_r <= {DIV_W{1'b0}};
      end else if (run) begin
         div_r <= tick ? {DIV_W{1'b0}} : div_r + 1'b1;
      end
   end

   uerx_vote u_vote (
      .clk     (CLK_SYS),
      .reset   (RESET),
      .tick    (tick),
      .din     (rx_s_r),
      .bit_o   (vbit),
      .noise_o (vnoise)
   );

   // frame closes at the last stop bit, or at the first stop bit if that one is low
   assign fin    = dec & ((st_r == S_STOP & (~vbit | ~TWO_STOP)) |
                          (st_r == S_STOP2));
   assign fin_fe = ~vbit;
   assign fin_nz = nz_r | vnoise;
   assign fin_pe = pe_r;
   assign msb    = NINE_BIT_SELECT ? sh_r[8] : sh_r[7];

   always @(posedge CLK_SYS) begin
      if (RESET) begin
         st_r  <= S_IDLE;
         ovs_r <= {`UERX_OVS_W{1'b0}};
         bit_r <= 4'h0;
         sh_r  <= 9'h000;
         nz_r  <= 1'b0;
         pe_r  <= 1'b0;
      end else if (run) begin
         if (tick) begin
            ovs_r <= ovs_r + 1'b1;
         end
         if (~rx_on) begin
            st_r <= S_IDLE;
         end else begin
            case (st_r)
               S_IDLE: begin
                  if (tick & ~rx_s_r) begin
                     st_r  <= S_START;
                     ovs_r <= 4'h1;
                  end
               end
               S_START: begin
                  if (dec) begin
                     if (vbit) begin
                        st_r <= S_IDLE;
                     end else begin
                        st_r  <= S_DATA;
                        bit_r <= 4'h0;
                        sh_r  <= 9'h000;
                        nz_r  <= vnoise;
                        pe_r  <= 1'b0;
                     end
                  end
               end
               S_DATA: begin
                  if (dec) begin
                     // shift register is overwritten on overrun too
                     sh_r[bit_r] <= vbit;
                     nz_r        <= nz_r | vnoise;
                     if (bit_r == last_bit) begin
                        st_r <= PARITY_ENABLE ? S_PAR : S_STOP;
                     end else begin
                        bit_r <= bit_r + 1'b1;
                     end
                  end
               end
               S_PAR: begin
                  if (dec) begin
                     pe_r <= vbit ^ par_exp(PARITY_TYPE, sh_r);
                     nz_r <= nz_r | vnoise;
                     st_r <= S_STOP;
                  end
               end
               S_STOP: begin
                  if (dec) begin
                     if (~vbit) begin
                        st_r <= S_BRK;
                     end else if (TWO_STOP) begin
                        st_r <= S_STOP2;
                        nz_r <= nz_r | vnoise;
                     end else begin
                        st_r <= S_IDLE;
                     end
                  end
               end
               S_STOP2: begin
                  if (dec) begin
                     st_r <= vbit ? S_IDLE : S_BRK;
                  end
               end
               S_BRK: begin
                  // a still-low line is not taken as a new start bit
                  if (tick & rx_s_r) begin
                     st_r <= S_IDLE;
                  end
               end
               default: begin
                  st_r <= S_IDLE;
               end
            endcase
         end
      end
   end

   always @(posedge CLK_SYS) begin
      if (RESET) begin
         RX_IDLE_FLAG <= 1'b1;
      end else if (run) begin
         RX_IDLE_FLAG <= ~(st_r == S_START | st_r == S_DATA);
      end
   end

   // four entries; a fifth word waits only in the shifter
   assign pop       = run & DATA_READ & (RX_COUNT != 3'h0);
   assign push      = fin & ((RX_COUNT != `UERX_DEPTH) | pop);
   assign ovr       = fin & ~push;
   assign cnt_after = RX_COUNT + {2'h0, push} - {2'h0, pop};

   always @(posedge CLK_SYS) begin
      if (push) begin
         mem[wr_ptr_r] <= {fin_pe, fin_fe, fin_nz, sh_r};
      end
   end

   always @(posedge CLK_SYS) begin
      if (RESET) begin
         wr_ptr_r <= 2'h0;
         rd_ptr_r <= 2'h0;
         RX_COUNT <= 3'h0;
      end else begin
         if (push) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         RX_COUNT <= cnt_after;
      end
   end

   // head word and its per-word flags, one cycle after any change
   always @(posedge CLK_SYS) begin
      if (RESET) begin
         RX_DATA            <= 9'h000;
         NOISE_FLAG         <= 1'b0;
         FRAME_ERR_FLAG     <= 1'b0;
         PARITY_ERR_FLAG    <= 1'b0;
         RX_DATA_AVAIL_FLAG <= 1'b0;
      end else if (run) begin
         RX_DATA_AVAIL_FLAG <= (RX_COUNT != 3'h0);
         if (RX_COUNT != 3'h0) begin
            RX_DATA         <= mem[rd_ptr_r][8:0];
            NOISE_FLAG      <= mem[rd_ptr_r][`UERX_F_NZ];
            FRAME_ERR_FLAG  <= mem[rd_ptr_r][`UERX_F_FE];
            PARITY_ERR_FLAG <= mem[rd_ptr_r][`UERX_F_PE];
         end else begin
            RX_DATA         <= 9'h000;
            NOISE_FLAG      <= 1'b0;
            FRAME_ERR_FLAG  <= 1'b0;
            PARITY_ERR_FLAG <= 1'b0;
         end
      end
   end

   // status access arms the clearing data access
   assign seq_rd = run & DATA_READ & stat_seen_r;
   assign seq_wr = run & DATA_WRITE & stat_seen_r;

   always @(posedge CLK_SYS) begin
      if (RESET) begin
         stat_seen_r <= 1'b0;
      end else if (run) begin
         if (STATUS_ACCESS) begin
            stat_seen_r <= 1'b1;
         end else if (DATA_WRITE) begin
            stat_seen_r <= 1'b0;
         end else if (DATA_READ & (cnt_after == 3'h0)) begin
            // reads keep the sequence open until the buffer drains
            stat_seen_r <= 1'b0;
         end
      end
   end

   // set wins over clear on every hardware flag
   always @(posedge CLK_SYS) begin
      if (RESET) begin
         OVERRUN_FLAG       <= 1'b0;
         TX_EMPTY_FLAG      <= 1'b0;
         TX_IDLE_FLAG       <= 1'b0;
         STICKY_NOISE_FLAG  <= 1'b0;
         STICKY_FRAME_FLAG  <= 1'b0;
         STICKY_PARITY_FLAG <= 1'b0;
      end else if (run) begin
         OVERRUN_FLAG  <= ovr | (OVERRUN_FLAG & ~seq_rd);
         TX_EMPTY_FLAG <= TX_EMPTY_SET | (TX_EMPTY_FLAG & ~seq_wr);
         TX_IDLE_FLAG  <= TX_IDLE_SET | (TX_IDLE_FLAG & ~seq_wr);
         STICKY_NOISE_FLAG  <= (fin & fin_nz) |
            (STICKY_NOISE_FLAG & ~STICKY_CLEAR[`UERX_STK_NZ]);
         STICKY_FRAME_FLAG  <= (fin & fin_fe) |
            (STICKY_FRAME_FLAG & ~STICKY_CLEAR[`UERX_STK_FE]);
         STICKY_PARITY_FLAG <= (fin & fin_pe) |
            (STICKY_PARITY_FLAG & ~STICKY_CLEAR[`UERX_STK_PE]);
      end
   end

   // wake only while stopped; data during the hold is ignored
   always @(posedge CLK_SYS) begin
      if (RESET) begin
         wake_pend_r <= 1'b0;
         WAKE_EVENT  <= 1'b0;
         hold_r      <= 8'h00;
         hold_act_r  <= 1'b0;
         wake_irq_r  <= 1'b0;
      end else begin
         WAKE_EVENT <= 1'b0;
         wake_irq_r <= 1'b0;
         if (~run & ~wake_pend_r & PIN_WAKE_ENABLE & PORT_ENABLE &
             RECEIVER_ENABLE & RX_IRQ_ENABLE & rx_d_r & ~rx_s_r) begin
            wake_pend_r <= 1'b1;
            WAKE_EVENT  <= 1'b1;
         end else if (run & wake_pend_r & ~hold_act_r) begin
            hold_act_r <= 1'b1;
            hold_r     <= 8'h00;
         end else if (run & hold_act_r) begin
            if (hold_r == WAKE_HOLD[7:0] - 8'h01) begin
               hold_act_r  <= 1'b0;
               wake_pend_r <= 1'b0;
               wake_irq_r  <= 1'b1;
            end else begin
               hold_r <= hold_r + 8'h01;
            end
         end
      end
   end

   // noise raises the error source too, like framing and parity errors
   assign e_rx  = push & RX_IRQ_ENABLE & (cnt_after >= RX_TRIG_LEVEL) &
                  (~ADDR_DETECT_ENABLE | msb);
   assign e_adr = push & ADDR_DETECT_ENABLE & msb;
   assign e_ovr = ovr & RX_IRQ_ENABLE;
   assign e_err = GLOBAL_ERROR_IRQ_ENABLE & fin &
                  (fin_nz | fin_fe | fin_pe);
   assign e_tx  = run & ((TX_EMPTY_SET & ~TX_EMPTY_FLAG & TX_EMPTY_IRQ_EN) |
                  (TX_IDLE_SET & ~TX_IDLE_FLAG & TX_IDLE_IRQ_EN));
   assign any_evt = e_rx | e_adr | e_ovr | e_err | e_tx | wake_irq_r;

   always @(posedge CLK_SYS) begin
      if (RESET) begin
         PORT_IRQ_N <= 1'b1;
      end else begin
         PORT_IRQ_N <= ~any_evt;
      end
   end

endmodule // uerx_top

// *** uerx_monitor.sv ***
`timescale 1ns/1ps
module uerx_monitor (
   input wire       CLK_SYS,
   input wire       RESET,
   input wire       PORT_CLK_RUN,
   input wire       RX_IRQ_ENABLE,
   input wire       ADDR_DETECT_ENABLE,
   input wire [2:0] RX_TRIG_LEVEL,
   input wire       PIN_WAKE_ENABLE,
   input wire       DATA_READ,
   input wire [2:0] STICKY_CLEAR,
   input wire [2:0] RX_COUNT,
   input wire       RX_DATA_AVAIL_FLAG,
   input wire       OVERRUN_FLAG,
   input wire       STICKY_FRAME_FLAG,
   input wire       WAKE_EVENT,
   input wire       PORT_IRQ_N
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (RESET);
   // past-reset guards keep reset-driven steps out of edge tests
   sequence push_s;
      !$past(RESET) && RX_COUNT > $past(RX_COUNT) && RX_IRQ_ENABLE &&
      !ADDR_DETECT_ENABLE && RX_COUNT >= RX_TRIG_LEVEL;
   endsequence
   sequence ovr_s;
      !$past(RESET) && $rose(OVERRUN_FLAG);
   endsequence
   sequence irq_s;
      ##[0:2] !PORT_IRQ_N;
   endsequence
   irq_pulse_a: assert property (!PORT_IRQ_N |=> PORT_IRQ_N)
      else $error("irq low for more than one cycle");
   push_irq_a: assert property (push_s |-> irq_s)
      else $error("no irq after word push");
   ovr_irq_a: assert property (ovr_s ##0 RX_IRQ_ENABLE |-> irq_s)
      else $error("no irq after overrun");
   ovr_keep_a: assert property (
      ovr_s |-> $past(RX_COUNT) == 3'h4 && RX_COUNT == 3'h4)
      else $error("overrun without a full buffer kept");
   count_max_a: assert property (RX_COUNT <= 3'h4)
      else $error("buffer count above four");
   ovr_clear_a: assert property (
      !$past(RESET) && $fell(OVERRUN_FLAG) |-> $past(DATA_READ))
      else $error("overrun cleared without a data read");
   avail_a: assert property (
      !$past(RESET) |-> RX_DATA_AVAIL_FLAG == ($past(RX_COUNT) != 3'h0))
      else $error("avail flag does not follow count");
   freeze_a: assert property (!PORT_CLK_RUN |=> $stable(RX_COUNT) &&
      $stable(OVERRUN_FLAG) && $stable(STICKY_FRAME_FLAG))
      else $error("state moved with port clock stopped");
   sticky_a: assert property (
      STICKY_FRAME_FLAG && !STICKY_CLEAR[1] |=> STICKY_FRAME_FLAG)
      else $error("sticky frame flag lost");
   wake_a: assert property (WAKE_EVENT |-> $past(PIN_WAKE_ENABLE &&
      RX_IRQ_ENABLE && !PORT_CLK_RUN) ##1 !WAKE_EVENT)
      else $error("bad wake pulse");
endmodule // uerx_monitor
bind uerx_top uerx_monitor u_mon (.*);

// *** uerx_line_model.sv ***
`timescale 1ns/1ps
module uerx_line_model #(
   parameter BIT_CLKS = 32
) (
   input  wire clk,
   output reg  rx_line
);
   initial rx_line = 1'b1;
   // start bit, then n bits lsb first; bits above 11 stay low (break)
   // bit g gets one flipped sample period near its middle (noise)
   task automatic send(input [11:0] v, input integer n, input integer g);
      integer b, i;
      for (b = -1; b < n; b = b + 1)
         for (i = 0; i < BIT_CLKS; i = i + 1) begin
            @(posedge clk);
            rx_line <= (b >= 0 && b < 12 && v[b]) ^ (b == g &&
                       i >= BIT_CLKS / 2 + 2 && i < BIT_CLKS / 2 + 4);
         end
      @(posedge clk);
      rx_line <= 1'b1;
   endtask
endmodule // uerx_line_model

// *** uart_rx_errors_irq_wake_test.sv ***
`timescale 1ns/1ps
module uart_rx_errors_irq_wake_test;
   localparam BITC = 32;
   reg         clk, rst, run, pe, re, nine, pen, two, rie, tei, tii;
   reg         gie, ade, wke, st, rd, wr, txs, tis;
   reg  [1:0]  ptyp;
   reg  [2:0]  trig, stc;
   reg  [11:0] notes [$];
   reg  [11:0] n;
   reg  [7:0]  irqs, i0;
   integer     err_count, check_count, k, j, t;
   wire        line, avail, ovr, idle, nzf, fef, pef, snz, sfe, spe;
   wire        txe, txi, wk, irq_n;
   wire [8:0]  rx_data;
   wire [2:0]  cnt;
   wire [11:0] sv;
   assign sv = {cnt, avail, ovr, idle, snz, sfe, spe, txe, txi, wk};

   uerx_top #(.WAKE_HOLD(4)) u_dut (
      .CLK_SYS(clk), .RESET(rst), .PORT_CLK_RUN(run), .RX_PIN(line),
      .BAUD_DIV(16'h0001), .PORT_ENABLE(pe), .RECEIVER_ENABLE(re),
      .NINE_BIT_SELECT(nine), .PARITY_ENABLE(pen), .PARITY_TYPE(ptyp),
      .TWO_STOP(two), .RX_TRIG_LEVEL(trig), .RX_IRQ_ENABLE(rie),
      .TX_EMPTY_IRQ_EN(tei), .TX_IDLE_IRQ_EN(tii),
      .GLOBAL_ERROR_IRQ_ENABLE(gie), .ADDR_DETECT_ENABLE(ade),
      .PIN_WAKE_ENABLE(wke), .STATUS_ACCESS(st), .DATA_READ(rd),
      .DATA_WRITE(wr), .STICKY_CLEAR(stc), .TX_EMPTY_SET(txs),
      .TX_IDLE_SET(tis), .RX_DATA(rx_data), .RX_COUNT(cnt),
      .RX_DATA_AVAIL_FLAG(avail), .RX_IDLE_FLAG(idle), .OVERRUN_FLAG(ovr),
      .NOISE_FLAG(nzf), .FRAME_ERR_FLAG(fef), .PARITY_ERR_FLAG(pef),
      .STICKY_NOISE_FLAG(snz), .STICKY_FRAME_FLAG(sfe),
      .STICKY_PARITY_FLAG(spe), .TX_EMPTY_FLAG(txe), .TX_IDLE_FLAG(txi),
      .WAKE_EVENT(wk), .PORT_IRQ_N(irq_n)
   );
   uerx_line_model #(.BIT_CLKS(BITC)) u_line (.clk(clk), .rx_line(line));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic chk(input [11:0] g, input [11:0] e);
      begin
         check_count = check_count + 1;
         if (g !== e) begin
            err_count = err_count + 1;
            $display("wrong value at %0t: got %h want %h", $time, g, e);
         end
      end
   endtask
   task automatic finish_test;
      begin
         $display("checks %0d errors %0d", check_count, err_count);
         if (err_count == 0 && check_count > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask
   task automatic tick(input integer c);
      repeat (c) @(posedge clk);
   endtask
   // state is judged between edges, once the edge's updates have landed
   task automatic look(input [11:0] e);
      begin
         @(negedge clk) chk(sv, e);
         @(posedge clk);
      end
   endtask
   task automatic pulse_clear(input [2:0] m);
      begin
         stc <= m;
         tick(1);
         stc <= 3'h0;
         look(12'h040);
      end
   endtask
   task automatic read1;
      begin
         rd <= 1'b1;
         tick(1);
         rd <= 1'b0;
         tick(2);
      end
   endtask
   task automatic drain;
      begin
         st <= 1'b1;
         tick(1);
         st <= 1'b0;
         for (k = 0; k < 6 && notes.size() > 0; k = k + 1)
            read1;
         read1;
      end
   endtask
   task automatic frm(input [31:0] d, input pb, input sb, input integer g,
                      input ex);
      reg [8:0]  dm;
      reg [11:0] v;
      integer    w;
      begin
         w = nine ? 9 : 8;
         dm = nine ? d[8:0] : {1'b0, d[7:0]};
         v = (12'hFFF << w) | {3'h0, dm};
         if (pen) begin
            v[w] = (ptyp[1] ? !ptyp[0] : ^dm ^ ptyp[0]) ^ pb;
            w = w + 1;
         end
         w = w + (two ? 2 : 1);
         v[w - 1] = !sb;
         if (ex) notes.push_back({pb & pen, sb, g < 12, dm});
         u_line.send(v, w, g);
      end
   endtask

   // a popped word is judged against the oldest note
   always @(posedge clk) begin
      if (irq_n === 1'b0) irqs <= irqs + 8'h01;
      if (!rst && run && rd && avail === 1'b1) begin
         n = (notes.size() > 0) ? notes.pop_front() : 12'hFFF;
         chk({pef, fef, nzf, rx_data}, n);
      end
   end

   initial begin
      #2000000;
      err_count = err_count + 1;
      finish_test;
   end

   initial begin
      {rst, run, pe, re, rie, trig} = 8'hF9;
      {nine, pen, two, tei, tii, gie, ade, wke, st, rd, wr, txs, tis} = 0;
      {ptyp, stc, irqs, err_count, check_count} = 0;
      k = $urandom(32'hF2C3);
      tick(3);
      rst <= 1'b0;
      tick(2);
      i0 = irqs;
      fork
         frm($urandom, 0, 0, 15, 1);
         begin
            tick(4 * BITC);
            look(12'h000);
         end
      join
      for (t = 0; t < 4; t = t + 1)
         frm($urandom, 0, 0, 15, t < 3);
      tick(4);
      look(12'h9C0);
      chk({4'h0, irqs - i0}, 12'h005);
      read1;
      look(12'h7C0);
      drain;
      look(12'h040);
      $display("test overrun done");
      pen <= 1'b1;
      gie <= 1'b1;
      for (t = 0; t < 4; t = t + 1) begin
         ptyp <= t[1:0];
         tick(1);
         frm($urandom, 0, 0, 15, 1);
         frm($urandom, 1, 0, 15, 1);
         drain;
      end
      look(12'h048);
      pulse_clear(3'h4);
      $display("test parity done");
      pen <= 1'b0;
      nine <= 1'b1;
      two <= 1'b1;
      tick(1);
      frm($urandom, 0, 0, 15, 1);
      frm($urandom, 0, 0, 3, 1);
      frm($urandom, 0, 1, 15, 1);
      tick(BITC);
      drain;
      look(12'h070);
      pulse_clear(3'h3);
      $display("test frame noise done");
      nine <= 1'b0;
      two <= 1'b0;
      tick(1);
      // break word: zero data, framing error, no noise
      notes.push_back(12'h400);
      u_line.send(12'h000, 30, 31);
      tick(2 * BITC);
      look(12'h350);
      drain;
      pulse_clear(3'h2);
      $display("test break done");
      ade <= 1'b1;
      tick(1);
      i0 = irqs;
      frm(32'h005, 0, 0, 15, 1);
      frm(32'h085, 0, 0, 15, 1);
      tick(4);
      chk({4'h0, irqs - i0}, 12'h001);
      // address detect is its own source; take it out to see the shared enable
      rie <= 1'b0;
      ade <= 1'b0;
      tick(1);
      i0 = irqs;
      frm(32'h085, 0, 0, 15, 1);
      tick(4);
      chk({4'h0, irqs - i0}, 12'h000);
      rie <= 1'b1;
      drain;
      $display("test address done");
      tei <= 1'b1;
      tii <= 1'b1;
      txs <= 1'b1;
      i0 = irqs;
      tick(1);
      txs <= 1'b0;
      // one idle cycle keeps the two pulses apart
      tick(1);
      tis <= 1'b1;
      tick(1);
      tis <= 1'b0;
      tick(3);
      look(12'h046);
      chk({4'h0, irqs - i0}, 12'h002);
      st <= 1'b1;
      tick(1);
      st <= 1'b0;
      wr <= 1'b1;
      tick(1);
      wr <= 1'b0;
      tick(2);
      look(12'h040);
      $display("test tx flags done");
      wke <= 1'b1;
      run <= 1'b0;
      tick(1);
      i0 = irqs;
      fork
         u_line.send(12'hF55, 9, 15);
         begin
            for (j = 0; j < 400 && wk !== 1'b1; j = j + 1)
               @(negedge clk);
            chk({11'h0, wk}, 12'h001);
            if (wk !== 1'b1) finish_test;
         end
      join
      look(12'h040);
      chk({4'h0, irqs - i0}, 12'h000);
      run <= 1'b1;
      tick(40);
      chk({4'h0, irqs - i0}, 12'h001);
      look(12'h040);
      $display("test wake done");
      finish_test;
   end
endmodule // uart_rx_errors_irq_wake_test
